// ### hdl/lpm_pkg.sv
// package for the low power mode controller
package lpm_pkg;
   localparam logic [11:0] LPM_CTRL_OFF = 12'h000;
   localparam logic [11:0] LPM_STAT_OFF = 12'h004;
   localparam logic [11:0] LPM_WAKE_OFF = 12'h008;
   localparam logic [11:0] LPM_PVD_OFF = 12'h00C;
   localparam logic [31:0] LPM_CTRL_RST = 32'h00000000;
   localparam logic [31:0] LPM_WAKE_RST = 32'h00000000;
   localparam logic [31:0] LPM_PVD_RST = 32'h00000000;
   // ctrl field positions
   localparam int LPM_CTRL_MODE_LSB = 0;
   localparam int LPM_CTRL_RET_BIT = 4;
   localparam int LPM_CTRL_CLKSEL_BIT = 5;
   localparam int LPM_CTRL_RTC_BIT = 6;
   localparam int LPM_CTRL_IOCFG_LSB = 8;
   // pvd field positions
   localparam int LPM_PVD_EN_BIT = 0;
   localparam int LPM_PVD_FALL_BIT = 1;
   localparam int LPM_PVD_RISE_BIT = 2;
   localparam int LPM_PVD_FLAG_BIT = 3;
   localparam int LPM_WAKE_SRCS = 9;
   localparam int LPM_SYNC_DEPTH = 3;
   localparam int LPM_CLK_HZ = 25000000;
   localparam int LPM_CPU_LP_MAX_HZ = 2000000;
   localparam logic [4:0] LPM_LP_DIV = 5'(LPM_CLK_HZ / LPM_CPU_LP_MAX_HZ);

   typedef enum logic [2:0]
   {
      LPM_SEL_STOP0 = 3'h0,
      LPM_SEL_STOP1 = 3'h1,
      LPM_SEL_STOP2 = 3'h2,
      LPM_SEL_STANDBY = 3'h3,
      LPM_SEL_SHUTDOWN = 3'h4,
      LPM_SEL_SLEEP = 3'h5,
      LPM_SEL_LPRUN = 3'h6,
      LPM_SEL_RUN = 3'h7
   } lpm_sel_t;

   typedef enum logic [1:0]
   {
      LPM_CLK_MSI4 = 2'h0,
      LPM_CLK_MSI48 = 2'h1,
      LPM_CLK_INTERNAL_FAST_OSCILLATOR = 2'h2
   } lpm_clk_t;

   typedef struct packed
   {
      logic main_core_regulator;
      logic low_power_core_regulator;
      logic radio_analog_regulator;
      logic core_supply_domain;
      logic core_low_leak;
      logic brownout_supervisor;
      logic supply_level_detector;
      logic slow_osc_run;
      logic fast_osc_req_ok;
      logic cpu_clk_run;
      logic radio_wait_ok;
      logic main_ram_bank;
      logic retainable_ram_bank;
      logic second_aux_ram_bank;
      logic io_hold;
      logic rtc_run;
   } lpm_pwr_t;
endpackage : lpm_pkg

// ### hdl/lpm_ctrl.sv
// low power mode controller with apb registers
`timescale 1ns/100ps
// Function
// - reset always lands in full run
// - main regulator in run, sleep, stop0
// - low-power regulator in lp modes, retention standby
// - all regulators off in shutdown; standby keeps only the low-power one for retention
// - lp run: cpu at 2 MHz, radio off
// - sleep stops only cpu clock, irq wakes
// - lp sleep only from lp run, returns there
// - stop keeps memories, slow oscillator running
// - stop0 main on, stop2 low leakage
// - fast oscillator requestable during stop
// - radio waits for events in stop
// - stop exit clock msi or internal_fast_oscillator
// - standby: core off, brownout active
// - standby loses rams except retainable bank
// - io hold configured state in standby
// - standby wake sources listed
// - standby wake clock is 16 MHz
// - brownout holds reset except in shutdown
// - voltage detector interrupt on chosen edges
// - higher of cpu and radio requests wins
// - shutdown wake clock is 4 MHz msi
module lpm_ctrl
   import lpm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_wfi,
   input wire logic cpu_event,
   input wire logic [2:0] radio_req,
   input wire logic [LPM_WAKE_SRCS-1:0] wake_in,
   input wire logic supply_below_bor,
   input wire logic supply_below_pvd,
   input wire logic fast_osc_periph_req,
   output lpm_pwr_t pwr,
   output lpm_clk_t sys_clk_sel,
   output logic [1:0] io_state,
   output logic fast_osc_en,
   output logic cpu_clk_div_en,
   output logic brownout_reset,
   output logic pvd_irq
);
   typedef enum {ST_RUN, ST_SLEEP, ST_LPRUN, ST_LPSLEEP, ST_STOP, ST_STANDBY, ST_SHUTDOWN} lpm_st_t;

   lpm_st_t state_reg, state_next;
   lpm_sel_t stop_lvl_reg, stop_lvl_next;
   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] wake_en_reg, wake_en_next;
   logic [31:0] pvd_reg, pvd_next;
   logic [31:0] prdata_next;
   logic pready_next, pslverr_next;
   lpm_pwr_t pwr_next;
   lpm_clk_t clk_reg, clk_next;
   logic [1:0] io_next;
   logic fast_osc_next, div_next, bor_next, irq_next;
   logic [LPM_WAKE_SRCS-1:0] wk_s1, wk_s2, wk_s3;
   logic [2:0] sup_s1, sup_s2, sup_s3;
   logic bor_lvl_reg, bor_lvl_next, pvd_lvl_reg, pvd_lvl_next;
   logic osc_lvl_reg, osc_lvl_next, pvd_set;
   logic wake_pend;
   lpm_sel_t sel, eff_sel;
   logic wr, rd;

   // three-stage synchronisers; a supply change counts once stages two and three agree, a wake counts only while both are high
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wk_s1 <= '0;
         wk_s2 <= '0;
         wk_s3 <= '0;
         sup_s1 <= '0;
         sup_s2 <= '0;
         sup_s3 <= '0;
      end
      else
      begin
         wk_s1 <= wake_in;
         wk_s2 <= wk_s1;
         wk_s3 <= wk_s2;
         sup_s1 <= {fast_osc_periph_req, supply_below_pvd, supply_below_bor};
         sup_s2 <= sup_s1;
         sup_s3 <= sup_s2;
      end
   end

   assign wr = psel && penable && pwrite && pready;
   assign rd = psel && !penable && !pwrite;
   // polarity already folded by the pin logic; enable masks each source
   assign wake_pend = |(wk_s2 & wk_s3 & wake_en_reg[LPM_WAKE_SRCS-1:0]);
   assign sel = lpm_sel_t'(ctrl_reg[LPM_CTRL_MODE_LSB +: 3]);

   // apb slave and register writes
   always_comb
   begin
      ctrl_next = ctrl_reg;
      wake_en_next = wake_en_reg;
      pvd_next = pvd_reg;
      prdata_next = prdata;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      bor_lvl_next = bor_lvl_reg;
      pvd_lvl_next = pvd_lvl_reg;
      osc_lvl_next = osc_lvl_reg;
      pvd_set = 1'b0;
      if (sup_s2[0] == sup_s3[0])
         bor_lvl_next = sup_s3[0];
      if (sup_s2[1] == sup_s3[1])
         pvd_lvl_next = sup_s3[1];
      if (sup_s2[2] == sup_s3[2])
         osc_lvl_next = sup_s3[2];
      // detector edges; set beats a same-cycle clear
      if (pvd_reg[LPM_PVD_EN_BIT] && pvd_lvl_next != pvd_lvl_reg)
      begin
         if ((pvd_lvl_next && pvd_reg[LPM_PVD_FALL_BIT]) ||
            (!pvd_lvl_next && pvd_reg[LPM_PVD_RISE_BIT]))
         begin
            pvd_set = 1'b1;
            pvd_next[LPM_PVD_FLAG_BIT] = 1'b1;
         end
      end
      // one wait state: answer on the second access edge
      if (psel && penable && !pready)
      begin
         pready_next = 1'b1;
         if (paddr != LPM_CTRL_OFF && paddr != LPM_STAT_OFF &&
            paddr != LPM_WAKE_OFF && paddr != LPM_PVD_OFF)
            pslverr_next = 1'b1;
      end
      // writes land on the completing edge, while pready is high
      if (wr)
      begin
         if (paddr == LPM_CTRL_OFF)
            ctrl_next = pwdata;
         else if (paddr == LPM_WAKE_OFF)
            wake_en_next = pwdata;
         else if (paddr == LPM_PVD_OFF)
         begin
            pvd_next[LPM_PVD_RISE_BIT:LPM_PVD_EN_BIT] = pwdata[LPM_PVD_RISE_BIT:LPM_PVD_EN_BIT];
            if (pwdata[LPM_PVD_FLAG_BIT] && !pvd_set)
               pvd_next[LPM_PVD_FLAG_BIT] = 1'b0;
         end
      end
      if (rd)
      begin
         if (paddr == LPM_CTRL_OFF)
            prdata_next = ctrl_reg;
         else if (paddr == LPM_STAT_OFF)
            prdata_next = {24'h000000, 1'b0, stop_lvl_reg, 1'b0, 3'(state_reg)};
         else if (paddr == LPM_WAKE_OFF)
            prdata_next = wake_en_reg;
         else if (paddr == LPM_PVD_OFF)
            prdata_next = pvd_reg;
         else
            prdata_next = 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= LPM_CTRL_RST;
         wake_en_reg <= LPM_WAKE_RST;
         pvd_reg <= LPM_PVD_RST;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         bor_lvl_reg <= 1'b0;
         pvd_lvl_reg <= 1'b0;
         osc_lvl_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         wake_en_reg <= wake_en_next;
         pvd_reg <= pvd_next;
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
         bor_lvl_reg <= bor_lvl_next;
         pvd_lvl_reg <= pvd_lvl_next;
         osc_lvl_reg <= osc_lvl_next;
      end
   end

   // mode sequencer
   always_comb
   begin
      state_next = state_reg;
      stop_lvl_next = stop_lvl_reg;
      clk_next = clk_reg;
      // the higher code wins, whether it is the deeper request or not
      eff_sel = (radio_req > sel) ? lpm_sel_t'(radio_req) : sel;
      case (state_reg)
         ST_RUN:
         begin
            if (cpu_wfi && !wake_pend && !cpu_event)
            begin
               if (eff_sel == LPM_SEL_SLEEP)
                  state_next = ST_SLEEP;
               else if (eff_sel == LPM_SEL_LPRUN && radio_req == LPM_SEL_STOP0)
                  state_next = ST_LPRUN;
               else if (eff_sel <= LPM_SEL_STOP2)
               begin
                  state_next = ST_STOP;
                  stop_lvl_next = eff_sel;
               end
               else if (eff_sel == LPM_SEL_STANDBY)
                  state_next = ST_STANDBY;
               else if (eff_sel == LPM_SEL_SHUTDOWN)
                  state_next = ST_SHUTDOWN;
            end
         end
         ST_SLEEP:
            if (cpu_event || wake_pend)
               state_next = ST_RUN;
         ST_LPRUN:
         begin
            if (sel == LPM_SEL_RUN || radio_req > LPM_SEL_STOP0)
               state_next = ST_RUN;
            else if (cpu_wfi && !wake_pend && !cpu_event && sel == LPM_SEL_SLEEP)
               state_next = ST_LPSLEEP;
         end
         ST_LPSLEEP:
            if (cpu_event || wake_pend)
               state_next = ST_LPRUN;
         ST_STOP:
            if (wake_pend || cpu_event || radio_req > LPM_SEL_STOP2)
            begin
               state_next = ST_RUN;
               // radio in use forces the 16 MHz oscillator
               clk_next = (ctrl_reg[LPM_CTRL_CLKSEL_BIT] || radio_req != LPM_SEL_STOP0)
                  ? LPM_CLK_INTERNAL_FAST_OSCILLATOR : LPM_CLK_MSI48;
            end
         ST_STANDBY:
            if (wake_pend || radio_req > LPM_SEL_STANDBY)
            begin
               state_next = ST_RUN;
               clk_next = LPM_CLK_INTERNAL_FAST_OSCILLATOR;
            end
         ST_SHUTDOWN:
            if (wake_pend)
            begin
               state_next = ST_RUN;
               clk_next = LPM_CLK_MSI4;
            end
         default:
            state_next = ST_RUN;
      endcase
      // brownout overrides any mode except shutdown
      if (bor_lvl_reg && state_reg != ST_SHUTDOWN)
      begin
         state_next = ST_RUN;
         clk_next = LPM_CLK_MSI4;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_RUN;
         stop_lvl_reg <= LPM_SEL_STOP0;
         clk_reg <= LPM_CLK_MSI4;
      end
      else
      begin
         state_reg <= state_next;
         stop_lvl_reg <= stop_lvl_next;
         clk_reg <= clk_next;
      end
   end

   // power domain decode, registered for clean outputs
   always_comb
   begin
      pwr_next = '0;
      pwr_next.brownout_supervisor = 1'b1;
      pwr_next.supply_level_detector = pvd_reg[LPM_PVD_EN_BIT];
      pwr_next.slow_osc_run = 1'b1;
      pwr_next.rtc_run = 1'b1;
      pwr_next.core_supply_domain = 1'b1;
      pwr_next.main_ram_bank = 1'b1;
      pwr_next.retainable_ram_bank = 1'b1;
      pwr_next.second_aux_ram_bank = 1'b1;
      io_next = 2'h0;
      div_next = 1'b0;
      fast_osc_next = 1'b0;
      case (state_next)
         ST_RUN, ST_SLEEP:
         begin
            pwr_next.main_core_regulator = 1'b1;
            pwr_next.radio_analog_regulator = 1'b1;
            pwr_next.radio_wait_ok = 1'b1;
            pwr_next.cpu_clk_run = (state_next == ST_RUN);
         end
         ST_LPRUN, ST_LPSLEEP:
         begin
            pwr_next.low_power_core_regulator = 1'b1;
            pwr_next.cpu_clk_run = (state_next == ST_LPRUN);
            div_next = 1'b1;
            fast_osc_next = osc_lvl_next;
         end
         ST_STOP:
         begin
            pwr_next.main_core_regulator = (stop_lvl_next == LPM_SEL_STOP0);
            pwr_next.low_power_core_regulator = (stop_lvl_next != LPM_SEL_STOP0);
            pwr_next.core_low_leak = (stop_lvl_next == LPM_SEL_STOP2);
            pwr_next.radio_analog_regulator = 1'b1;
            pwr_next.radio_wait_ok = 1'b1;
            pwr_next.fast_osc_req_ok = 1'b1;
            fast_osc_next = osc_lvl_next;
            pwr_next.rtc_run = ctrl_reg[LPM_CTRL_RTC_BIT];
         end
         ST_STANDBY:
         begin
            pwr_next.core_supply_domain = 1'b0;
            pwr_next.supply_level_detector = 1'b0;
            pwr_next.main_ram_bank = 1'b0;
            pwr_next.second_aux_ram_bank = 1'b0;
            pwr_next.retainable_ram_bank = ctrl_reg[LPM_CTRL_RET_BIT];
            // regulators stay off except retention supply
            pwr_next.low_power_core_regulator = ctrl_reg[LPM_CTRL_RET_BIT];
            pwr_next.io_hold = 1'b1;
            io_next = ctrl_reg[LPM_CTRL_IOCFG_LSB +: 2];
            pwr_next.rtc_run = ctrl_reg[LPM_CTRL_RTC_BIT];
            pwr_next.radio_wait_ok = 1'b1;
         end
         ST_SHUTDOWN:
         begin
            pwr_next = '0;
            pwr_next.slow_osc_run = 1'b1;
            pwr_next.rtc_run = ctrl_reg[LPM_CTRL_RTC_BIT];
            pwr_next.io_hold = 1'b1;
            io_next = ctrl_reg[LPM_CTRL_IOCFG_LSB +: 2];
         end
         default:
            pwr_next.main_core_regulator = 1'b1;
      endcase
      bor_next = bor_lvl_next && state_reg != ST_SHUTDOWN;
      irq_next = pvd_next[LPM_PVD_FLAG_BIT] && pvd_next[LPM_PVD_EN_BIT];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwr <= '0;
         sys_clk_sel <= LPM_CLK_MSI4;
         io_state <= 2'h0;
         fast_osc_en <= 1'b0;
         cpu_clk_div_en <= 1'b0;
         brownout_reset <= 1'b0;
         pvd_irq <= 1'b0;
      end
      else
      begin
         pwr <= pwr_next;
         sys_clk_sel <= clk_next;
         io_state <= io_next;
         fast_osc_en <= fast_osc_next;
         cpu_clk_div_en <= div_next;
         brownout_reset <= bor_next;
         pvd_irq <= irq_next;
      end
   end
endmodule : lpm_ctrl

// ### testbench/lpm_ctrl_asserts.sv
// concurrent checks on the controller ports
`timescale 1ns/100ps
module lpm_ctrl_chk
   import lpm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cpu_event,
   input wire logic supply_below_bor,
   input lpm_pwr_t pwr,
   input lpm_clk_t sys_clk_sel,
   input wire logic cpu_clk_div_en,
   input wire logic brownout_reset
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence in_standby;
      !pwr.core_supply_domain && pwr.brownout_supervisor;
   endsequence
   sequence core_back;
      pwr.core_supply_domain;
   endsequence
   sequence access_wait;
      psel && penable && !pready;
   endsequence
   apb_answer_a: assert property (access_wait |=> pready)
      else $error("no ready after access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_pairs_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   reg_excl_a: assert property (!(pwr.main_core_regulator && pwr.low_power_core_regulator))
      else $error("both core regulators on");
   core_off_a: assert property (!pwr.core_supply_domain |->
      !pwr.main_core_regulator && !pwr.radio_analog_regulator)
      else $error("regulator on with core off");
   lprun_regs_a: assert property (cpu_clk_div_en |->
      pwr.low_power_core_regulator && !pwr.radio_analog_regulator)
      else $error("slow cpu clock outside low power regulator");
   bor_hold_a: assert property ((supply_below_bor && pwr.brownout_supervisor) [*6]
      |-> brownout_reset)
      else $error("low supply without brownout reset");
   standby_wake_a: assert property (in_standby ##1 core_back |->
      sys_clk_sel == LPM_CLK_INTERNAL_FAST_OSCILLATOR)
      else $error("standby exit clock wrong");
   event_abort_a: assert property (cpu_event [*3] ##0 pwr.cpu_clk_run |=> pwr.cpu_clk_run)
      else $error("cpu stopped with event pending");
endmodule : lpm_ctrl_chk

bind lpm_ctrl lpm_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .cpu_event(cpu_event),
   .supply_below_bor(supply_below_bor), .pwr(pwr), .sys_clk_sel(sys_clk_sel),
   .cpu_clk_div_en(cpu_clk_div_en), .brownout_reset(brownout_reset));

// ### testbench/lpm_far_model.sv
// model of the application cpu and the wake sources
`timescale 1ns/100ps
module lpm_far_model
   import lpm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sleep_req,
   input wire logic [LPM_WAKE_SRCS-1:0] wake_req,
   input wire logic cpu_clk_run,
   output logic cpu_wfi,
   output logic [LPM_WAKE_SRCS-1:0] wake_in
);
   logic [2:0] run_cnt;
   logic run_d;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cpu_wfi <= 1'b0;
         wake_in <= '0;
         run_cnt <= 3'h0;
         run_d <= 1'b1;
      end
      else
      begin
         run_d <= cpu_clk_run;
         run_cnt <= (cpu_wfi && cpu_clk_run) ? run_cnt + 3'h1 : 3'h0;
         // wfi retires when the clock returns, or soon if it never stopped
         if (sleep_req)
            cpu_wfi <= 1'b1;
         else if ((cpu_clk_run && !run_d) || run_cnt == 3'h4)
            cpu_wfi <= 1'b0;
         // a source stays raised until the cpu runs again
         if (|wake_req)
            wake_in <= wake_in | wake_req;
         else if (cpu_clk_run && !cpu_wfi)
            wake_in <= '0;
      end
   end
endmodule : lpm_far_model

// ### testbench/lpm_ctrl_bench.sv
// self-checking bench for the low power mode controller
`timescale 1ns/100ps
module lpm_ctrl_bench
   import lpm_pkg::*;
   ;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic cpu_event = 1'b0;
   logic [2:0] radio_req = 3'h0;
   logic bor_low = 1'b0;
   logic pvd_low = 1'b0;
   logic osc_req = 1'b0;
   logic sleep_req = 1'b0;
   logic [LPM_WAKE_SRCS-1:0] wake_req = '0;
   logic [LPM_WAKE_SRCS-1:0] wake_in;
   logic [31:0] prdata;
   logic pready, pslverr, cpu_wfi, fast_osc_en, cpu_clk_div_en, brownout_reset, pvd_irq;
   logic [1:0] io_state;
   lpm_pwr_t pwr;
   lpm_clk_t sys_clk_sel;
   logic [31:0] seed = 32'h00000060;
   logic [31:0] rd, v;
   logic err;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;

   lpm_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_wfi(cpu_wfi), .cpu_event(cpu_event), .radio_req(radio_req),
      .wake_in(wake_in), .supply_below_bor(bor_low), .supply_below_pvd(pvd_low),
      .fast_osc_periph_req(osc_req), .pwr(pwr), .sys_clk_sel(sys_clk_sel),
      .io_state(io_state), .fast_osc_en(fast_osc_en), .cpu_clk_div_en(cpu_clk_div_en),
      .brownout_reset(brownout_reset), .pvd_irq(pvd_irq));
   lpm_far_model i_far (.pclk(pclk), .presetn(presetn), .sleep_req(sleep_req),
      .wake_req(wake_req), .cpu_clk_run(pwr.cpu_clk_run), .cpu_wfi(cpu_wfi),
      .wake_in(wake_in));

   always #20 pclk = ~pclk;

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         failures++;
         print_verdict();
      end
   end

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function logic [31:0] ctrl_word(input logic [2:0] m, input logic [1:0] io,
      input logic ret, input logic hsi);
      return {22'h000000, io, 2'h0, hsi, ret, 1'b0, m};
   endfunction : ctrl_word

   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task enter(input logic [31:0] ctrl);
      apb(1'b1, LPM_CTRL_OFF, ctrl);
      @(posedge pclk);
      sleep_req <= 1'b1;
      @(posedge pclk);
      sleep_req <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask : enter

   task wake_and_event(input int b);
      @(posedge pclk);
      wake_req <= (9'h001 << b);
      cpu_event <= (b > 8);
      repeat (8) @(posedge pclk);
      wake_req <= '0;
      cpu_event <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask : wake_and_event

   task print_verdict();
      if (failures == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check({pwr.cpu_clk_run, pwr.main_core_regulator}, 2'h3);
      apb(1'b0, LPM_CTRL_OFF, 32'h00000000);
      check(rd, LPM_CTRL_RST);
      apb(1'b0, 12'h010, 32'h00000000);
      check(err, 1'b1);
      check(rd, 32'h00000000);
      for (int i = 0; i < 4; i++)
      begin
         v = xs();
         apb(1'b1, LPM_WAKE_OFF, v);
         apb(1'b0, LPM_WAKE_OFF, 32'h00000000);
         check(rd, v);
         apb(1'b1, LPM_CTRL_OFF, v);
         apb(1'b0, LPM_CTRL_OFF, 32'h00000000);
         check(rd & 32'h00000377, v & 32'h00000377);
      end
      apb(1'b1, LPM_WAKE_OFF, 32'h000001FF);
      enter(ctrl_word(LPM_SEL_SLEEP, 2'h0, 1'b0, 1'b0));
      check({pwr.cpu_clk_run, pwr.main_core_regulator}, 2'h1);
      wake_and_event(9);
      check(pwr.cpu_clk_run, 1'b1);
      for (int lvl = 0; lvl < 3; lvl++)
      begin
         v = xs();
         osc_req <= 1'b1;
         // radio idle, so either exit clock may be chosen
         enter(ctrl_word(lvl[2:0], 2'h0, 1'b0, v[0]));
         check(pwr.main_core_regulator, lvl == 0);
         check(pwr.low_power_core_regulator, lvl != 0);
         check(pwr.core_low_leak, lvl == 2);
         check({pwr.main_ram_bank, pwr.second_aux_ram_bank, pwr.slow_osc_run}, 3'h7);
         check({pwr.radio_wait_ok, fast_osc_en}, 2'h3);
         osc_req <= 1'b0;
         wake_and_event(int'(xs() % 9));
         check(pwr.cpu_clk_run, 1'b1);
         check(sys_clk_sel == LPM_CLK_INTERNAL_FAST_OSCILLATOR, v[0]);
      end
      v = xs();
      enter(ctrl_word(LPM_SEL_STANDBY, v[1:0], 1'b1, 1'b0));
      check({pwr.core_supply_domain, pwr.main_core_regulator}, 2'h0);
      check({pwr.radio_analog_regulator, pwr.low_power_core_regulator}, 2'h1);
      check(pwr.brownout_supervisor, 1'b1);
      check({pwr.main_ram_bank, pwr.second_aux_ram_bank, pwr.retainable_ram_bank}, 3'h1);
      check({pwr.io_hold, io_state}, {1'b1, v[1:0]});
      wake_and_event(int'(xs() % 9));
      check({pwr.core_supply_domain, sys_clk_sel}, {1'b1, LPM_CLK_INTERNAL_FAST_OSCILLATOR});
      // radio_req stays idle, as software must ensure before this mode
      enter(ctrl_word(LPM_SEL_LPRUN, 2'h0, 1'b0, 1'b0));
      check({cpu_clk_div_en, pwr.low_power_core_regulator, pwr.main_core_regulator}, 3'h6);
      enter(ctrl_word(LPM_SEL_SLEEP, 2'h0, 1'b0, 1'b0));
      check({pwr.cpu_clk_run, pwr.low_power_core_regulator}, 2'h1);
      wake_and_event(9);
      check({pwr.cpu_clk_run, cpu_clk_div_en}, 2'h3);
      apb(1'b1, LPM_PVD_OFF, 32'h00000003);
      pvd_low <= 1'b1;
      repeat (8) @(posedge pclk);
      check(pvd_irq, 1'b1);
      pvd_low <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(1'b1, LPM_PVD_OFF, 32'h0000000D);
      @(posedge pclk);
      check(pvd_irq, 1'b0);
      pvd_low <= 1'b1;
      repeat (8) @(posedge pclk);
      check(pvd_irq, 1'b0);
      pvd_low <= 1'b0;
      repeat (8) @(posedge pclk);
      check(pvd_irq, 1'b1);
      bor_low <= 1'b1;
      repeat (8) @(posedge pclk);
      check(brownout_reset, 1'b1);
      bor_low <= 1'b0;
      repeat (8) @(posedge pclk);
      check(brownout_reset, 1'b0);
      // radio request outranks software and forces the fast exit clock
      radio_req <= LPM_SEL_STOP2;
      enter(ctrl_word(LPM_SEL_STOP1, 2'h0, 1'b0, 1'b0));
      check({pwr.core_low_leak, pwr.low_power_core_regulator}, 2'h3);
      wake_and_event(int'(xs() % 9));
      check(sys_clk_sel, LPM_CLK_INTERNAL_FAST_OSCILLATOR);
      radio_req <= LPM_SEL_STOP0;
      v = xs();
      enter(ctrl_word(LPM_SEL_SHUTDOWN, v[1:0], 1'b0, 1'b0));
      check({pwr.main_core_regulator, pwr.low_power_core_regulator}, 2'h0);
      check({pwr.radio_analog_regulator, pwr.brownout_supervisor}, 2'h0);
      check({pwr.io_hold, io_state}, {1'b1, v[1:0]});
      bor_low <= 1'b1;
      repeat (8) @(posedge pclk);
      check(brownout_reset, 1'b0);
      bor_low <= 1'b0;
      repeat (8) @(posedge pclk);
      wake_and_event(int'(xs() % 9));
      check(sys_clk_sel, LPM_CLK_MSI4);
      print_verdict();
   end
endmodule : lpm_ctrl_bench
